//--- hdl/pmbp_pkg.sv
package pmbp_pkg;
    localparam int          ADDR_W        = 22;
    localparam int          EE_ADDR_W     = 10;
    // Protection register and device id addresses
    localparam logic [21:0] CFG_BLK_CP    = 22'h300008;
    localparam logic [21:0] CFG_BOOT_CP   = 22'h300009;
    localparam logic [21:0] CFG_BLK_WRT   = 22'h30000A;
    localparam logic [21:0] CFG_BOOT_WRT  = 22'h30000B;
    localparam logic [21:0] CFG_BLK_TRD   = 22'h30000C;
    localparam logic [21:0] CFG_BOOT_TRD  = 22'h30000D;
    localparam logic [21:0] DEVID_LO_ADDR = 22'h3FFFFE;
    localparam logic [21:0] DEVID_HI_ADDR = 22'h3FFFFF;
    // Field positions
    localparam int          BLK_FIELD_LSB = 0;
    localparam int          EE_BIT        = 7;
    localparam int          BOOT_BIT      = 6;
    localparam int          CFGWP_BIT     = 5;
    // Unprogrammed value of every protection bit
    localparam logic        PROT_RESET    = 1'b1;
    // Block indices; boot block is index 4 of a 5-bit protection vector
    localparam logic [2:0]  BLK_0         = 3'h0;
    localparam logic [2:0]  BLK_1         = 3'h1;
    localparam logic [2:0]  BLK_2         = 3'h2;
    localparam logic [2:0]  BLK_3         = 3'h3;
    localparam logic [2:0]  BLK_BOOT      = 3'h4;
    localparam logic [2:0]  BLK_NONE      = 3'h7;
    // Last address of each block per memory size
    localparam logic [21:0] S8_BOOT_END   = 22'h0001FF;
    localparam logic [21:0] S8_B0_END     = 22'h000FFF;
    localparam logic [21:0] S8_B1_END     = 22'h001FFF;
    localparam logic [21:0] S16_BOOT_END  = 22'h0007FF;
    localparam logic [21:0] S16_B0_END    = 22'h001FFF;
    localparam logic [21:0] S16_B1_END    = 22'h003FFF;
    localparam logic [21:0] S32_B2_END    = 22'h005FFF;
    localparam logic [21:0] S32_B3_END    = 22'h007FFF;
    localparam logic [21:0] S64_B0_END    = 22'h003FFF;
    localparam logic [21:0] S64_B1_END    = 22'h007FFF;
    localparam logic [21:0] S64_B2_END    = 22'h00BFFF;
    localparam logic [21:0] S64_B3_END    = 22'h00FFFF;

    typedef enum logic [1:0] {SZ_8K, SZ_16K, SZ_32K, SZ_64K} pmbp_size_type;
endpackage : pmbp_pkg

//--- hdl/pmbp_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pmbp_checker #(
    parameter pmbp_pkg::pmbp_size_type SIZE      = pmbp_pkg::SZ_64K,
    parameter logic [15:0]             DEVICE_ID = 16'h5A3C // Arbitrary value
) (
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    input  wire logic        i_tbl_req,
    input  wire logic        i_tbl_write,
    input  wire logic [21:0] i_tbl_addr,
    input  wire logic [21:0] i_exec_addr,
    input  wire logic [7:0]  i_tbl_wdata,
    input  wire logic [7:0]  i_mem_rdata,
    input  wire logic        i_ee_req,
    input  wire logic        i_ee_write,
    input  wire logic [9:0]  i_ee_addr,
    input  wire logic [7:0]  i_ee_wdata,
    input  wire logic        i_prog_mode,
    input  wire logic        i_prog_req,
    input  wire logic        i_prog_write,
    input  wire logic        i_prog_ee,
    input  wire logic        i_prog_chip_erase,
    input  wire logic        i_prog_block_erase,
    input  wire logic [2:0]  i_prog_erase_blk,
    input  wire logic [21:0] i_prog_addr,
    input  wire logic [7:0]  i_prog_wdata,
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data,
    output logic             o_mem_we,
    output logic [21:0]      o_mem_addr,
    output logic [7:0]       o_mem_wdata,
    output logic             o_prog_rd_valid,
    output logic [7:0]       o_prog_rd_data,
    output logic             o_prog_denied,
    output logic             o_ee_we,
    output logic             o_ee_rd,
    output logic [9:0]       o_ee_addr,
    output logic [7:0]       o_ee_wdata,
    output logic [17:0]      o_prot_bits
);
    typedef struct packed {
        logic        pm_meta;
        logic        pm_sync;
        logic [4:0]  cp;
        logic [4:0]  wrt;
        logic [4:0]  ebtr;
        logic        eeprom_external_protect;
        logic        eeprom_write_protect;
        logic        config_write_protect;
        logic        rd_valid;
        logic [7:0]  rd_data;
        logic        mem_we;
        logic [21:0] mem_addr;
        logic [7:0]  mem_wdata;
        logic        prog_rd_valid;
        logic [7:0]  prog_rd_data;
        logic        prog_denied;
        logic        ee_we;
        logic        ee_rd;
        logic [9:0]  ee_addr;
        logic [7:0]  ee_wdata;
    } pmbp_state_type;

    pmbp_state_type st_reg;
    pmbp_state_type st_next;

    // Address to block index for the configured memory size
    function automatic logic [2:0] blk_of(input logic [21:0] a);
        logic [2:0] b;
        b = pmbp_pkg::BLK_NONE;
        unique case (SIZE)
            pmbp_pkg::SZ_8K: begin
                if (a <= pmbp_pkg::S8_BOOT_END) b = pmbp_pkg::BLK_BOOT;
                else if (a <= pmbp_pkg::S8_B0_END) b = pmbp_pkg::BLK_0;
                else if (a <= pmbp_pkg::S8_B1_END) b = pmbp_pkg::BLK_1;
            end
            pmbp_pkg::SZ_16K, pmbp_pkg::SZ_32K: begin
                if (a <= pmbp_pkg::S16_BOOT_END) b = pmbp_pkg::BLK_BOOT;
                else if (a <= pmbp_pkg::S16_B0_END) b = pmbp_pkg::BLK_0;
                else if (a <= pmbp_pkg::S16_B1_END) b = pmbp_pkg::BLK_1;
                else if (SIZE == pmbp_pkg::SZ_32K && a <= pmbp_pkg::S32_B2_END)
                    b = pmbp_pkg::BLK_2;
                else if (SIZE == pmbp_pkg::SZ_32K && a <= pmbp_pkg::S32_B3_END)
                    b = pmbp_pkg::BLK_3;
            end
            pmbp_pkg::SZ_64K: begin
                if (a <= pmbp_pkg::S16_BOOT_END) b = pmbp_pkg::BLK_BOOT;
                else if (a <= pmbp_pkg::S64_B0_END) b = pmbp_pkg::BLK_0;
                else if (a <= pmbp_pkg::S64_B1_END) b = pmbp_pkg::BLK_1;
                else if (a <= pmbp_pkg::S64_B2_END) b = pmbp_pkg::BLK_2;
                else if (a <= pmbp_pkg::S64_B3_END) b = pmbp_pkg::BLK_3;
            end
        endcase
        return b;
    endfunction : blk_of
    function automatic logic is_cfg(input logic [21:0] a);
        return (a >= pmbp_pkg::CFG_BLK_CP) && (a <= pmbp_pkg::CFG_BOOT_TRD);
    endfunction : is_cfg
    // Read value of protection registers, device id or zeros
    function automatic logic [7:0] misc_rd(input pmbp_state_type s, input logic [21:0] a);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            pmbp_pkg::CFG_BLK_CP:    r[pmbp_pkg::BLK_FIELD_LSB +: 4] = s.cp[3:0];
            pmbp_pkg::CFG_BLK_WRT:   r[pmbp_pkg::BLK_FIELD_LSB +: 4] = s.wrt[3:0];
            pmbp_pkg::CFG_BLK_TRD:   r[pmbp_pkg::BLK_FIELD_LSB +: 4] = s.ebtr[3:0];
            pmbp_pkg::CFG_BOOT_CP: begin
                r[pmbp_pkg::EE_BIT]   = s.eeprom_external_protect;
                r[pmbp_pkg::BOOT_BIT] = s.cp[4];
            end
            pmbp_pkg::CFG_BOOT_WRT: begin
                r[pmbp_pkg::EE_BIT]    = s.eeprom_write_protect;
                r[pmbp_pkg::BOOT_BIT]  = s.wrt[4];
                r[pmbp_pkg::CFGWP_BIT] = s.config_write_protect;
            end
            pmbp_pkg::CFG_BOOT_TRD:  r[pmbp_pkg::BOOT_BIT] = s.ebtr[4];
            pmbp_pkg::DEVID_LO_ADDR: r = DEVICE_ID[7:0];
            pmbp_pkg::DEVID_HI_ADDR: r = DEVICE_ID[15:8];
            default:                 r = 8'h00;
        endcase
        return r;
    endfunction : misc_rd
    // Clear-only write of a protection register
    function automatic pmbp_state_type cfg_wr(input pmbp_state_type s, input logic [21:0] a,
                                              input logic [7:0] w, input logic ext);
        pmbp_state_type n;
        n = s;
        unique case (a)
            pmbp_pkg::CFG_BLK_CP:  n.cp[3:0] = s.cp[3:0] & w[pmbp_pkg::BLK_FIELD_LSB +: 4];
            pmbp_pkg::CFG_BLK_WRT: n.wrt[3:0] = s.wrt[3:0] & w[pmbp_pkg::BLK_FIELD_LSB +: 4];
            pmbp_pkg::CFG_BLK_TRD: n.ebtr[3:0] = s.ebtr[3:0] & w[pmbp_pkg::BLK_FIELD_LSB +: 4];
            pmbp_pkg::CFG_BOOT_CP: begin
                n.eeprom_external_protect   = s.eeprom_external_protect & w[pmbp_pkg::EE_BIT];
                n.cp[4] = s.cp[4] & w[pmbp_pkg::BOOT_BIT];
            end
            pmbp_pkg::CFG_BOOT_WRT: begin
                n.eeprom_write_protect   = s.eeprom_write_protect & w[pmbp_pkg::EE_BIT];
                n.wrt[4] = s.wrt[4] & w[pmbp_pkg::BOOT_BIT];
                n.config_write_protect   = s.config_write_protect & (w[pmbp_pkg::CFGWP_BIT] | ~ext);
            end
            pmbp_pkg::CFG_BOOT_TRD: n.ebtr[4] = s.ebtr[4] & w[pmbp_pkg::BOOT_BIT];
            default:                n = s;
        endcase
        return n;
    endfunction : cfg_wr
    logic       prog_act;
    logic [2:0] tgt_blk;
    logic [2:0] exe_blk;
    logic [2:0] prg_blk;
    logic       prot_set_ok;

    assign prog_act    = st_reg.pm_sync && i_prog_req;
    assign tgt_blk     = blk_of(i_tbl_addr);
    assign exe_blk     = blk_of(i_exec_addr);
    assign prg_blk     = blk_of(i_prog_addr);
    assign prot_set_ok = prog_act && (i_prog_chip_erase || i_prog_block_erase);
    always_comb begin
        st_next               = st_reg;
        st_next.pm_meta       = i_prog_mode;
        st_next.pm_sync       = st_reg.pm_meta;
        st_next.rd_valid      = 1'b0;
        st_next.rd_data       = 8'h00;
        st_next.mem_we        = 1'b0;
        st_next.prog_rd_valid = 1'b0;
        st_next.prog_rd_data  = 8'h00;
        st_next.prog_denied   = 1'b0;
        st_next.ee_we         = 1'b0;
        st_next.ee_rd         = 1'b0;
        if (prog_act) begin
            if (i_prog_chip_erase) begin
                st_next.cp   = '1;
                st_next.wrt  = '1;
                st_next.ebtr = '1;
                st_next.eeprom_external_protect  = 1'b1;
                st_next.eeprom_write_protect = 1'b1;
                st_next.config_write_protect = 1'b1;
            end else if (i_prog_block_erase) begin
                if (i_prog_erase_blk <= pmbp_pkg::BLK_BOOT) begin
                    st_next.cp[i_prog_erase_blk]   = 1'b1;
                    st_next.wrt[i_prog_erase_blk]  = 1'b1;
                    st_next.ebtr[i_prog_erase_blk] = 1'b1;
                end
            end else if (i_prog_ee) begin
                st_next.ee_addr  = i_prog_addr[pmbp_pkg::EE_ADDR_W-1:0];
                st_next.ee_wdata = i_prog_wdata;
                if (!st_reg.eeprom_external_protect || (i_prog_write && !st_reg.eeprom_write_protect)) begin
                    st_next.prog_denied = 1'b1;
                end else begin
                    st_next.ee_we = i_prog_write;
                    st_next.ee_rd = !i_prog_write;
                end
            end else if (prg_blk == pmbp_pkg::BLK_NONE) begin
                if (i_prog_write && is_cfg(i_prog_addr) && st_reg.config_write_protect) begin
                    st_next = cfg_wr(st_next, i_prog_addr, i_prog_wdata, 1'b1);
                end else if (i_prog_write) begin
                    st_next.prog_denied = 1'b1;
                end else begin
                    st_next.prog_rd_valid = 1'b1;
                    st_next.prog_rd_data  = misc_rd(st_reg, i_prog_addr);
                end
            end else if (!st_reg.cp[prg_blk]) begin
                st_next.prog_denied = 1'b1;
            end else if (i_prog_write) begin
                if (st_reg.wrt[prg_blk]) begin
                    st_next.mem_we    = 1'b1;
                    st_next.mem_addr  = i_prog_addr;
                    st_next.mem_wdata = i_prog_wdata;
                end else begin
                    st_next.prog_denied = 1'b1;
                end
            end else begin
                st_next.prog_rd_valid = 1'b1;
                st_next.prog_rd_data  = i_mem_rdata;
            end
        end else begin
            if (i_tbl_req && i_tbl_write) begin
                if (tgt_blk == pmbp_pkg::BLK_NONE) begin
                    if (is_cfg(i_tbl_addr) && st_reg.config_write_protect) begin
                        st_next = cfg_wr(st_next, i_tbl_addr, i_tbl_wdata, 1'b0);
                    end
                end else if (st_reg.wrt[tgt_blk]) begin
                    st_next.mem_we    = 1'b1;
                    st_next.mem_addr  = i_tbl_addr;
                    st_next.mem_wdata = i_tbl_wdata;
                end
            end else if (i_tbl_req) begin
                st_next.rd_valid = 1'b1;
                if (tgt_blk == pmbp_pkg::BLK_NONE) begin
                    st_next.rd_data = misc_rd(st_reg, i_tbl_addr);
                end else if (st_reg.ebtr[tgt_blk] || exe_blk == tgt_blk) begin
                    st_next.rd_data = i_mem_rdata;
                end
            end
            if (i_ee_req) begin
                st_next.ee_addr  = i_ee_addr;
                st_next.ee_wdata = i_ee_wdata;
                st_next.ee_we    = i_ee_write && st_reg.eeprom_write_protect;
                st_next.ee_rd    = !i_ee_write;
            end
        end
    end
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            st_reg      <= '0;
            st_reg.cp   <= {5{pmbp_pkg::PROT_RESET}};
            st_reg.wrt  <= {5{pmbp_pkg::PROT_RESET}};
            st_reg.ebtr <= {5{pmbp_pkg::PROT_RESET}};
            st_reg.eeprom_external_protect  <= pmbp_pkg::PROT_RESET;
            st_reg.eeprom_write_protect <= pmbp_pkg::PROT_RESET;
            st_reg.config_write_protect <= pmbp_pkg::PROT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rd_valid      = st_reg.rd_valid;
    assign o_rd_data       = st_reg.rd_data;
    assign o_mem_we        = st_reg.mem_we;
    assign o_mem_addr      = st_reg.mem_addr;
    assign o_mem_wdata     = st_reg.mem_wdata;
    assign o_prog_rd_valid = st_reg.prog_rd_valid;
    assign o_prog_rd_data  = st_reg.prog_rd_data;
    assign o_prog_denied   = st_reg.prog_denied;
    assign o_ee_we         = st_reg.ee_we;
    assign o_ee_rd         = st_reg.ee_rd;
    assign o_ee_addr       = st_reg.ee_addr;
    assign o_ee_wdata      = st_reg.ee_wdata;
    assign o_prot_bits     = {st_reg.cp, st_reg.wrt, st_reg.ebtr,
                              st_reg.eeprom_external_protect, st_reg.eeprom_write_protect, st_reg.config_write_protect};

    logic core_rd;
    logic core_wr;
    assign core_rd = !prog_act && i_tbl_req && !i_tbl_write;
    assign core_wr = !prog_act && i_tbl_req && i_tbl_write;

    chk_unimp_read_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        core_rd && tgt_blk == pmbp_pkg::BLK_NONE && !is_cfg(i_tbl_addr)
        && i_tbl_addr < pmbp_pkg::DEVID_LO_ADDR |=> o_rd_valid && o_rd_data == 8'h00)
        else $error("Unimplemented read not zero");
    chk_write_refused: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        core_wr && tgt_blk != pmbp_pkg::BLK_NONE && !st_reg.wrt[tgt_blk] |=> !o_mem_we)
        else $error("Write into protected block passed");
    chk_same_blk_read: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        core_rd && tgt_blk != pmbp_pkg::BLK_NONE && exe_blk == tgt_blk
        |=> o_rd_data == $past(i_mem_rdata))
        else $error("Same-block read lost data");
    chk_cross_read_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        core_rd && tgt_blk != pmbp_pkg::BLK_NONE && exe_blk != tgt_blk
        && !st_reg.ebtr[tgt_blk] |=> o_rd_valid && o_rd_data == 8'h00)
        else $error("Cross-block read not zeroed");
    chk_bits_clear_only: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !prot_set_ok |=> (o_prot_bits & ~$past(o_prot_bits)) == 18'h00000)
        else $error("Protection bit rose without erase");
    chk_chip_erase_ones: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        prog_act && i_prog_chip_erase |=> o_prot_bits == 18'h3FFFF && !o_prog_denied)
        else $error("Chip erase did not set bits");
    chk_ee_ext_block: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        prog_act && !i_prog_chip_erase && !i_prog_block_erase && i_prog_ee && !st_reg.eeprom_external_protect
        |=> o_prog_denied && !o_ee_we && !o_ee_rd)
        else $error("Protected EEPROM reached by programmer");
    chk_ee_write_block: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !st_reg.eeprom_write_protect && !prot_set_ok |=> !o_ee_we)
        else $error("EEPROM write passed protection");
    chk_ee_core_read: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !prog_act && i_ee_req && !i_ee_write |=> o_ee_rd && !o_ee_we)
        else $error("Core EEPROM read refused");
    chk_cfg_wp_core: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !prog_act |=> $stable(st_reg.config_write_protect))
        else $error("Core changed config write protect");
    chk_ext_protect: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        core_rd && tgt_blk != pmbp_pkg::BLK_NONE && !st_reg.cp[tgt_blk]
        && (st_reg.ebtr[tgt_blk] || exe_blk == tgt_blk) |=> o_rd_data == $past(i_mem_rdata))
        else $error("External protect blocked core read");
endmodule : pmbp_checker
`default_nettype wire

//--- testbench/pmbp_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmbp_flash_model (
    input  wire logic        i_clock,
    input  wire logic        i_prog_active,
    input  wire logic [21:0] i_tbl_addr,
    input  wire logic [21:0] i_prog_addr,
    input  wire logic        i_we,
    input  wire logic [21:0] i_waddr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata
);
    logic [7:0]  mem [0:65535];
    logic [21:0] rd_addr;
    // Programmer address is presented while it is requesting
    assign rd_addr = i_prog_active ? i_prog_addr : i_tbl_addr;
    // Nothing lives past 64K; a non-zero pattern there makes a leak visible
    assign o_rdata = (rd_addr < 22'h010000) ? mem[rd_addr[15:0]] : 8'hA5;
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h3C;
        end
    end
    always @(posedge i_clock) begin
        if (i_we && (i_waddr < 22'h010000)) begin
            mem[i_waddr[15:0]] <= i_wdata;
        end
    end
endmodule : pmbp_flash_model
`default_nettype wire

//--- testbench/test_program_memory_block_protection.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR at %0t got %h expected %h", $time, (got), (exp)); end end
module test_program_memory_block_protection;
    localparam logic [15:0] DEV_ID = 16'hC3E1; // Arbitrary value
    logic        i_clock = 1'h0, i_sys_rst = 1'h1, i_prog_mode = 1'h0;
    logic        i_tbl_req = 1'h0, i_tbl_write = 1'h0, i_ee_req = 1'h0, i_ee_write = 1'h0;
    logic        i_prog_req = 1'h0, i_prog_write = 1'h0, i_prog_ee = 1'h0;
    logic        i_prog_chip_erase = 1'h0, i_prog_block_erase = 1'h0;
    logic [2:0]  i_prog_erase_blk = 3'h0;
    logic [21:0] i_tbl_addr = 22'h0, i_exec_addr = 22'h0, i_prog_addr = 22'h0, o_mem_addr;
    logic [9:0]  i_ee_addr = 10'h0, o_ee_addr;
    logic [7:0]  i_tbl_wdata = 8'h0, i_ee_wdata = 8'h0, i_prog_wdata = 8'h0, i_mem_rdata;
    logic [7:0]  o_rd_data, o_mem_wdata, o_prog_rd_data, o_ee_wdata, rd8_data;
    logic        o_rd_valid, o_mem_we, o_prog_rd_valid, o_prog_denied, o_ee_we, o_ee_rd;
    logic [17:0] o_prot_bits, prot8_bits, prot;
    int          mismatches = 0, checks_done = 0, cycles = 0;
    // Block edges paired with an executing address just across the edge, except 22'hFFFF, paired with 22'h0
    logic [21:0] tgt [9] = '{22'h7FF, 22'h800, 22'h3FFF, 22'h4000, 22'h7FFF,
                             22'h8000, 22'hBFFF, 22'hC000, 22'hFFFF};
    logic [21:0] oth [9] = '{22'h800, 22'h7FF, 22'h4000, 22'h3FFF, 22'h8000,
                             22'h7FFF, 22'hC000, 22'hBFFF, 22'h0};

    pmbp_checker #(.SIZE(pmbp_pkg::SZ_64K), .DEVICE_ID(DEV_ID)) uut (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_tbl_req(i_tbl_req),
        .i_tbl_write(i_tbl_write), .i_tbl_addr(i_tbl_addr), .i_exec_addr(i_exec_addr),
        .i_tbl_wdata(i_tbl_wdata), .i_mem_rdata(i_mem_rdata), .i_ee_req(i_ee_req),
        .i_ee_write(i_ee_write), .i_ee_addr(i_ee_addr), .i_ee_wdata(i_ee_wdata),
        .i_prog_mode(i_prog_mode), .i_prog_req(i_prog_req), .i_prog_write(i_prog_write),
        .i_prog_ee(i_prog_ee), .i_prog_chip_erase(i_prog_chip_erase),
        .i_prog_block_erase(i_prog_block_erase), .i_prog_erase_blk(i_prog_erase_blk),
        .i_prog_addr(i_prog_addr), .i_prog_wdata(i_prog_wdata), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .o_prog_rd_valid(o_prog_rd_valid),
        .o_prog_rd_data(o_prog_rd_data), .o_prog_denied(o_prog_denied), .o_ee_we(o_ee_we),
        .o_ee_rd(o_ee_rd), .o_ee_addr(o_ee_addr), .o_ee_wdata(o_ee_wdata),
        .o_prot_bits(o_prot_bits));
    pmbp_checker #(.SIZE(pmbp_pkg::SZ_8K), .DEVICE_ID(DEV_ID)) uut_8k (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_tbl_req(i_tbl_req),
        .i_tbl_write(i_tbl_write), .i_tbl_addr(i_tbl_addr), .i_exec_addr(i_exec_addr),
        .i_tbl_wdata(i_tbl_wdata), .i_mem_rdata(i_mem_rdata), .i_ee_req(i_ee_req),
        .i_ee_write(i_ee_write), .i_ee_addr(i_ee_addr), .i_ee_wdata(i_ee_wdata),
        .i_prog_mode(i_prog_mode), .i_prog_req(i_prog_req), .i_prog_write(i_prog_write),
        .i_prog_ee(i_prog_ee), .i_prog_chip_erase(i_prog_chip_erase),
        .i_prog_block_erase(i_prog_block_erase), .i_prog_erase_blk(i_prog_erase_blk),
        .i_prog_addr(i_prog_addr), .i_prog_wdata(i_prog_wdata), .o_rd_valid(),
        .o_rd_data(rd8_data), .o_mem_we(), .o_mem_addr(), .o_mem_wdata(), .o_prog_rd_valid(),
        .o_prog_rd_data(), .o_prog_denied(), .o_ee_we(), .o_ee_rd(), .o_ee_addr(),
        .o_ee_wdata(), .o_prot_bits(prot8_bits));
    pmbp_flash_model flash (
        .i_clock(i_clock), .i_prog_active(i_prog_req), .i_tbl_addr(i_tbl_addr),
        .i_prog_addr(i_prog_addr), .i_we(o_mem_we), .i_waddr(o_mem_addr),
        .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

    initial begin
        forever #10 i_clock = ~i_clock;
    end

    function automatic logic [7:0] pat(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction : pat

    task give_verdict;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if ((mismatches == 0) && (checks_done > 0)) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Kind 0 core table, 1 core EEPROM, 2 programmer flash, 3 programmer EEPROM
    task acc(input logic [1:0] k, input logic w, input logic [21:0] a,
             input logic [21:0] x, input logic [7:0] d);
        @(posedge i_clock);
        i_tbl_req <= (k == 2'h0);
        i_ee_req <= (k == 2'h1);
        i_prog_req <= k[1];
        i_prog_ee <= k[0];
        {i_tbl_write, i_ee_write, i_prog_write} <= {3{w}};
        {i_tbl_addr, i_prog_addr, i_exec_addr, i_ee_addr} <= {a, a, x, a[9:0]};
        {i_tbl_wdata, i_ee_wdata, i_prog_wdata} <= {3{d}};
        @(posedge i_clock);
        {i_tbl_req, i_ee_req, i_prog_req} <= 3'h0;
        #1;
    endtask : acc

    task erase(input logic chip, input logic [2:0] b);
        @(posedge i_clock);
        {i_prog_req, i_prog_chip_erase, i_prog_block_erase} <= {1'h1, chip, ~chip};
        i_prog_erase_blk <= b;
        @(posedge i_clock);
        {i_prog_req, i_prog_chip_erase, i_prog_block_erase} <= 3'h0;
        #1;
    endtask : erase

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        prot = 18'h3FFFF;
        repeat (20) @(posedge i_clock);
        i_sys_rst <= 1'h0;
        #1;
        `CHK(o_prot_bits, prot);
        acc(2'h0, 1'h0, 22'h4100, 22'h100, 8'h0);
        `CHK(o_rd_data, pat(22'h4100));
        `CHK(rd8_data, 8'h00);
        acc(2'h0, 1'h0, 22'h10000, 22'h100, 8'h0);
        `CHK({o_rd_valid, o_rd_data}, 9'h100);
        acc(2'h0, 1'h0, pmbp_pkg::DEVID_LO_ADDR, 22'h100, 8'h0);
        `CHK(o_rd_data, DEV_ID[7:0]);
        acc(2'h0, 1'h0, pmbp_pkg::DEVID_HI_ADDR, 22'h100, 8'h0);
        `CHK(o_rd_data, DEV_ID[15:8]);
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BLK_TRD, 22'h100, 8'hF0);
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BOOT_TRD, 22'h100, 8'hBF);
        prot &= ~18'h000F8;
        `CHK(o_prot_bits, prot);
        for (int i = 0; i < 9; i++) begin
            acc(2'h0, 1'h0, tgt[i], tgt[i], 8'h0);
            `CHK(o_rd_data, pat(tgt[i]));
            acc(2'h0, 1'h0, tgt[i], oth[i], 8'h0);
            `CHK(o_rd_data, 8'h00);
        end
        acc(2'h0, 1'h0, 22'h200, 22'h1FF, 8'h0);
        `CHK(o_rd_data, pat(22'h200));
        `CHK(rd8_data, 8'h00);
        acc(2'h0, 1'h0, 22'h1FFF, 22'h1000, 8'h0);
        `CHK(rd8_data, pat(22'h1FFF));
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BLK_TRD, 22'h100, 8'hFF);
        `CHK(o_prot_bits, prot);
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BLK_WRT, 22'h100, 8'hFE);
        prot &= ~18'h00100;
        acc(2'h0, 1'h1, 22'h1000, 22'h100, 8'h5A);
        `CHK(o_mem_we, 1'h0);
        acc(2'h0, 1'h0, 22'h1000, 22'h1000, 8'h0);
        `CHK(o_rd_data, pat(22'h1000));
        acc(2'h0, 1'h1, 22'h5000, 22'h100, 8'h5A);
        `CHK({o_mem_we, o_mem_addr, o_mem_wdata}, {1'h1, 22'h5000, 8'h5A});
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BOOT_WRT, 22'h100, 8'hDF);
        `CHK(o_prot_bits, prot);
        acc(2'h1, 1'h1, 22'h155, 22'h100, 8'h33);
        `CHK({o_ee_we, o_ee_addr, o_ee_wdata}, {1'h1, 10'h155, 8'h33});
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BOOT_WRT, 22'h100, 8'h7F);
        prot &= ~18'h00002;
        acc(2'h1, 1'h1, 22'h155, 22'h100, 8'h44);
        `CHK(o_ee_we, 1'h0);
        acc(2'h1, 1'h0, 22'h155, 22'h100, 8'h0);
        `CHK(o_ee_rd, 1'h1);
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BLK_CP, 22'h100, 8'hFD);
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BOOT_CP, 22'h100, 8'h7F);
        prot &= ~18'h04004;
        `CHK(o_prot_bits, prot);
        `CHK(prot8_bits, prot);
        acc(2'h0, 1'h0, 22'h5000, 22'h5000, 8'h0);
        `CHK(o_rd_data, 8'h5A);
        @(posedge i_clock);
        i_prog_mode <= 1'h1;
        repeat (3) @(posedge i_clock);
        acc(2'h2, 1'h0, 22'h5000, 22'h0, 8'h0);
        `CHK({o_prog_denied, o_prog_rd_valid}, 2'h2);
        acc(2'h2, 1'h0, 22'h1000, 22'h0, 8'h0);
        `CHK({o_prog_rd_valid, o_prog_rd_data}, {1'h1, pat(22'h1000)});
        acc(2'h3, 1'h0, 22'h155, 22'h0, 8'h0);
        `CHK({o_prog_denied, o_ee_rd}, 2'h2);
        acc(2'h2, 1'h1, pmbp_pkg::CFG_BOOT_WRT, 22'h0, 8'hDF);
        prot &= ~18'h00001;
        `CHK(o_prot_bits, prot);
        acc(2'h2, 1'h1, pmbp_pkg::CFG_BLK_CP, 22'h0, 8'h00);
        `CHK({o_prog_denied, o_prot_bits}, {1'h1, prot});
        erase(1'h1, 3'h0);
        `CHK(o_prot_bits, 18'h3FFFF);
        acc(2'h0, 1'h1, pmbp_pkg::CFG_BLK_WRT, 22'h100, 8'hFD);
        `CHK(o_prot_bits, 18'h3FDFF);
        erase(1'h0, 3'h1);
        `CHK(o_prot_bits, 18'h3FFFF);
        give_verdict();
    end
endmodule : test_program_memory_block_protection
`default_nettype wire
